/* File: logic/spwp_ctrl.sv */
// spi flash command, write-enable, lock and write-cycle logic
`timescale 1ns/1ps
module spwp_ctrl #(
	parameter int MEM_AW = 20,
	parameter int PUW_CYCLES = spwp_pkg::PUW_CYC
) (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic spi_clk_i,
	input wire logic cs_n_i,
	input wire logic serial_in_i,
	input wire logic wp_n_i,
	input wire logic hw_reset_n_i,
	output logic serial_out_o,
	output logic serial_out_oe_n_o,
	output logic write_in_progress_o,
	output logic standby_o,
	output logic deep_pd_o
);
	localparam int SEC_W = MEM_AW - spwp_pkg::SECTOR_AW;
	localparam int NSEC = 1 << SEC_W;
	localparam logic [MEM_AW-1:0] M_PAGE = MEM_AW'((1 << spwp_pkg::PAGE_AW) - 1);
	localparam logic [MEM_AW-1:0] M_SUB = MEM_AW'((1 << spwp_pkg::SUBSEC_AW) - 1);
	localparam logic [MEM_AW-1:0] M_SEC = MEM_AW'((1 << spwp_pkg::SECTOR_AW) - 1);

	// ---------------------------------------------------------------
	// pin synchronisers and edge detection
	// ---------------------------------------------------------------
	logic [2:0] clk_s;
	logic [2:0] cs_s;
	logic [1:0] din_s;
	logic [1:0] wp_s;
	logic [1:0] hrst_s;
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			clk_s <= 3'h0;
			cs_s <= 3'h7;
			din_s <= 2'h0;
			wp_s <= 2'h3;
			hrst_s <= 2'h0;
		end else begin
			clk_s <= {clk_s[1:0], spi_clk_i};
			cs_s <= {cs_s[1:0], cs_n_i};
			din_s <= {din_s[0], serial_in_i};
			wp_s <= {wp_s[0], wp_n_i};
			hrst_s <= {hrst_s[0], hw_reset_n_i};
		end
	end
	// clock and data share the same delay, so the sampled bit lines up with the edge
	wire rise = clk_s[1] & ~clk_s[2];
	wire fall = ~clk_s[1] & clk_s[2];
	wire sel = ~cs_s[1];
	wire cs_fall = ~cs_s[1] & cs_s[2];
	wire cs_rise = cs_s[1] & ~cs_s[2];
	wire srst = ~hrst_s[1];

	// ---------------------------------------------------------------
	// state declarations
	// ---------------------------------------------------------------
	logic [6:0] sh_reg;
	logic [2:0] bit_reg;
	logic [2:0] bytes_reg;
	logic [7:0] op_reg;
	logic [23:0] addr_reg;
	logic [7:0] wptr_reg;
	logic [7:0] data_reg;
	logic [7:0] tx_reg;
	logic drive_reg;
	logic [MEM_AW-1:0] rd_addr_reg;
	logic wel_reg;
	logic [2:0] bp_reg;
	logic swd_reg;
	logic dpd_reg;
	logic armed_reg;
	logic puw_done_reg;
	logic [15:0] puw_reg;
	logic [NSEC-1:0] wl_reg;
	logic [NSEC-1:0] ld_reg;
	spwp_pkg::spwp_cyc_t cyc_reg;
	logic pw_reg;
	logic [MEM_AW-1:0] cur_reg;
	logic [MEM_AW-1:0] last_reg;
	logic [255:0] vld_reg;
	logic [7:0] pbuf [0:255];
	logic [7:0] mem [0:(1<<MEM_AW)-1];

	wire busy = (cyc_reg != spwp_pkg::CY_IDLE);
	wire [7:0] byte_w = {sh_reg, din_s[1]};
	wire byte_done = sel & rise & (bit_reg == 3'h7) & ~srst;
	wire [7:0] op_now = (bytes_reg == spwp_pkg::BC_NONE) ? byte_w : op_reg;
	wire [SEC_W-1:0] sec = addr_reg[MEM_AW-1:spwp_pkg::SECTOR_AW];
	wire [MEM_AW-1:0] tgt = addr_reg[MEM_AW-1:0];
	wire hw_protected_mode = swd_reg & ~wp_s[1];
	wire rd_ok = armed_reg & ~dpd_reg & ~srst;
	wire whole = (bit_reg == 3'h0);
	wire [7:0] status = {swd_reg, 2'h0, bp_reg, wel_reg, busy};
	wire [7:0] lock_byte = {6'h00, ld_reg[sec], wl_reg[sec]};
	wire [MEM_AW-1:0] rd_a = (bytes_reg == spwp_pkg::BC_A3) ?
		{addr_reg[MEM_AW-1:8], byte_w} : rd_addr_reg;
	wire is_data = (bytes_reg == spwp_pkg::BC_HDR) | (bytes_reg == spwp_pkg::BC_DATA);
	wire is_pgw = (op_reg == spwp_pkg::PAGE_REWRITE_CMD) |
		(op_reg == spwp_pkg::PAGE_PROGRAM_CMD);
	wire base_ok = cs_rise & whole & armed_reg & puw_done_reg & ~busy & ~srst;
	wire commit = base_ok & ~dpd_reg;

	// ---------------------------------------------------------------
	// power-on delay and first-select arming
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			puw_reg <= 16'h0000;
			puw_done_reg <= 1'b0;
		end else if (puw_reg == 16'(PUW_CYCLES)) begin
			puw_done_reg <= 1'b1;
		end else begin
			puw_reg <= puw_reg + 16'h0001;
		end
	end
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			armed_reg <= 1'b0;
		end else if (cs_fall) begin
			armed_reg <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// serial receive
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sh_reg <= 7'h00;
			bit_reg <= 3'h0;
			bytes_reg <= spwp_pkg::BC_NONE;
			op_reg <= 8'h00;
			addr_reg <= 24'h000000;
			wptr_reg <= 8'h00;
			data_reg <= 8'h00;
		end else if (srst || cs_fall) begin
			bit_reg <= 3'h0;
			bytes_reg <= spwp_pkg::BC_NONE;
		end else if (sel && rise) begin
			sh_reg <= byte_w[6:0];
			bit_reg <= bit_reg + 3'h1;
			if (bit_reg == 3'h7) begin
				if (bytes_reg != spwp_pkg::BC_DATA) begin
					bytes_reg <= bytes_reg + 3'h1;
				end
				case (bytes_reg)
					spwp_pkg::BC_NONE: op_reg <= byte_w;
					spwp_pkg::BC_OP: addr_reg[23:16] <= byte_w;
					spwp_pkg::BC_SR: addr_reg[15:8] <= byte_w;
					spwp_pkg::BC_A3: begin
						addr_reg[7:0] <= byte_w;
						wptr_reg <= byte_w;
					end
					default: begin
						data_reg <= byte_w;
						wptr_reg <= wptr_reg + 8'h01;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// serial transmit; output only while selected and answering
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			tx_reg <= 8'h00;
			drive_reg <= 1'b0;
			rd_addr_reg <= '0;
		end else if (srst || cs_fall) begin
			drive_reg <= 1'b0;
		end else if (byte_done) begin
			if (op_now == spwp_pkg::STATUS_READ_CMD && rd_ok) begin
				tx_reg <= status;
				drive_reg <= 1'b1;
			end else if (op_now == spwp_pkg::DATA_READ_CMD && bytes_reg >= spwp_pkg::BC_A3 &&
				rd_ok && !busy) begin
				tx_reg <= mem[rd_a];
				rd_addr_reg <= rd_a + MEM_AW'(1);
				drive_reg <= 1'b1;
			end else if (op_now == spwp_pkg::LOCK_READ_CMD &&
				bytes_reg >= spwp_pkg::BC_A3 && rd_ok && !busy) begin
				tx_reg <= lock_byte;
				drive_reg <= 1'b1;
			end
		end else if (sel && fall) begin
			tx_reg <= {tx_reg[6:0], 1'b0};
		end
	end
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			serial_out_o <= 1'b0;
			serial_out_oe_n_o <= 1'b1;
		end else begin
			if (sel && fall) begin
				serial_out_o <= tx_reg[7];
			end
			serial_out_oe_n_o <= ~(sel & drive_reg & ~srst);
		end
	end

	// ---------------------------------------------------------------
	// command decode at deselect
	// ---------------------------------------------------------------
	spwp_pkg::spwp_cyc_t go_mode;
	logic [MEM_AW-1:0] go_mask;
	logic set_wel;
	logic clr_wel;
	logic wr_sr;
	logic wr_lock;
	logic set_dpd;
	logic clr_dpd;
	always_comb begin
		go_mode = spwp_pkg::CY_IDLE;
		go_mask = '0;
		set_wel = 1'b0;
		clr_wel = 1'b0;
		wr_sr = 1'b0;
		wr_lock = 1'b0;
		set_dpd = 1'b0;
		clr_dpd = base_ok & dpd_reg & (op_reg == spwp_pkg::PD_RELEASE_CMD) &
			(bytes_reg == spwp_pkg::BC_OP);
		if (commit) begin
			case (op_reg)
				spwp_pkg::WR_ENABLE_CMD: set_wel = (bytes_reg == spwp_pkg::BC_OP);
				spwp_pkg::WR_DISABLE_CMD: clr_wel = (bytes_reg == spwp_pkg::BC_OP);
				spwp_pkg::STATUS_WRITE_CMD: begin
					wr_sr = (bytes_reg == spwp_pkg::BC_SR) & wel_reg & ~hw_protected_mode;
				end
				spwp_pkg::LOCK_WRITE_CMD: begin
					if (bytes_reg == spwp_pkg::BC_DATA && wel_reg) begin
						clr_wel = 1'b1;
						wr_lock = ~ld_reg[sec];
					end
				end
				spwp_pkg::PAGE_REWRITE_CMD, spwp_pkg::PAGE_PROGRAM_CMD: begin
					if (bytes_reg == spwp_pkg::BC_DATA && wel_reg) begin
						clr_wel = 1'b1;
						go_mask = M_PAGE;
						if (!wl_reg[sec]) begin
							go_mode = (op_reg == spwp_pkg::PAGE_REWRITE_CMD) ?
								spwp_pkg::CY_FILL : spwp_pkg::CY_PROG;
						end
					end
				end
				spwp_pkg::PAGE_ERASE_CMD, spwp_pkg::SUBSECTOR_ERASE_CMD,
				spwp_pkg::SECTOR_ERASE_CMD: begin
					if (bytes_reg == spwp_pkg::BC_HDR && wel_reg) begin
						clr_wel = 1'b1;
						if (op_reg == spwp_pkg::PAGE_ERASE_CMD) begin
							go_mask = M_PAGE;
						end else if (op_reg == spwp_pkg::SUBSECTOR_ERASE_CMD) begin
							go_mask = M_SUB;
						end else begin
							go_mask = M_SEC;
						end
						if (!wl_reg[sec]) begin
							go_mode = spwp_pkg::CY_ERASE;
						end
					end
				end
				spwp_pkg::BULK_ERASE_CMD: begin
					if (bytes_reg == spwp_pkg::BC_OP && wel_reg) begin
						clr_wel = 1'b1;
						go_mask = '1;
						if (wl_reg == '0 && bp_reg == 3'h0) begin
							go_mode = spwp_pkg::CY_ERASE;
						end
					end
				end
				spwp_pkg::DEEP_PD_CMD: set_dpd = (bytes_reg == spwp_pkg::BC_OP);
				default: ;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// status, latch, power mode and sector locks
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wel_reg <= 1'b0;
		end else if (srst || clr_wel) begin
			wel_reg <= 1'b0;
		end else if (set_wel) begin
			wel_reg <= 1'b1;
		end
	end
	// area protect and disable bits survive the reset pin: only rst_n_i loads their reset values
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			bp_reg <= spwp_pkg::BP_RESET;
			swd_reg <= spwp_pkg::SWD_RESET;
		end else if (wr_sr) begin
			bp_reg <= addr_reg[16+spwp_pkg::SR_BP_LSB +: 3];
			swd_reg <= addr_reg[16+spwp_pkg::SR_SWD];
		end
	end
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			dpd_reg <= 1'b0;
		end else if (srst || clr_dpd) begin
			dpd_reg <= 1'b0;
		end else if (set_dpd) begin
			dpd_reg <= 1'b1;
		end
	end
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			wl_reg <= {NSEC{spwp_pkg::LOCK_RESET}};
			ld_reg <= {NSEC{spwp_pkg::LOCK_RESET}};
		end else if (srst) begin
			wl_reg <= {NSEC{spwp_pkg::LOCK_RESET}};
			ld_reg <= {NSEC{spwp_pkg::LOCK_RESET}};
		end else if (wr_lock) begin
			wl_reg[sec] <= data_reg[spwp_pkg::LOCK_WL];
			ld_reg[sec] <= data_reg[spwp_pkg::LOCK_LD];
		end
	end
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			write_in_progress_o <= 1'b0;
			standby_o <= 1'b0;
			deep_pd_o <= 1'b0;
		end else begin
			write_in_progress_o <= busy;
			standby_o <= ~sel & ~busy & ~dpd_reg;
			deep_pd_o <= dpd_reg;
		end
	end

	// ---------------------------------------------------------------
	// internal write cycle, one byte per clock
	// ---------------------------------------------------------------
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cyc_reg <= spwp_pkg::CY_IDLE;
			pw_reg <= 1'b0;
			cur_reg <= '0;
			last_reg <= '0;
		end else if (srst) begin
			cyc_reg <= spwp_pkg::CY_IDLE;
		end else begin
			case (cyc_reg)
				spwp_pkg::CY_IDLE: begin
					if (go_mode != spwp_pkg::CY_IDLE) begin
						cyc_reg <= go_mode;
						pw_reg <= (go_mode == spwp_pkg::CY_FILL);
						cur_reg <= tgt & ~go_mask;
						last_reg <= tgt | go_mask;
					end
				end
				spwp_pkg::CY_FILL, spwp_pkg::CY_ERASE: begin
					if (cur_reg == last_reg) begin
						cur_reg <= last_reg & ~M_PAGE;
						if (cyc_reg == spwp_pkg::CY_FILL) begin
							cyc_reg <= spwp_pkg::CY_ERASE;
						end else begin
							cyc_reg <= pw_reg ? spwp_pkg::CY_PROG : spwp_pkg::CY_IDLE;
						end
					end else begin
						cur_reg <= cur_reg + MEM_AW'(1);
					end
				end
				default: begin
					if (cur_reg == last_reg) begin
						cyc_reg <= spwp_pkg::CY_IDLE;
					end else begin
						cur_reg <= cur_reg + MEM_AW'(1);
					end
				end
			endcase
		end
	end
	always_ff @(posedge mclk_i) begin
		if (!srst && cyc_reg == spwp_pkg::CY_ERASE) begin
			mem[cur_reg] <= spwp_pkg::ERASED_BYTE;
		end else if (!srst && cyc_reg == spwp_pkg::CY_PROG) begin
			mem[cur_reg] <= mem[cur_reg] &
				(vld_reg[cur_reg[7:0]] ? pbuf[cur_reg[7:0]] : spwp_pkg::ERASED_BYTE);
		end
	end
	// buffer loads are blocked while busy so a running cycle keeps its data
	always_ff @(posedge mclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			vld_reg <= '0;
		end else if (byte_done && !busy && bytes_reg == spwp_pkg::BC_NONE) begin
			vld_reg <= '0;
		end else if (byte_done && !busy && is_data && is_pgw) begin
			vld_reg[wptr_reg] <= 1'b1;
		end else if (cyc_reg == spwp_pkg::CY_FILL) begin
			vld_reg[cur_reg[7:0]] <= 1'b1;
		end
	end
	always_ff @(posedge mclk_i) begin
		if (byte_done && !busy && is_data && is_pgw) begin
			pbuf[wptr_reg] <= byte_w;
		end else if (cyc_reg == spwp_pkg::CY_FILL && !vld_reg[cur_reg[7:0]]) begin
			pbuf[cur_reg[7:0]] <= mem[cur_reg];
		end
	end
endmodule

/* File: logic/spwp_pkg.sv */
// package: opcodes, status layout, sizes and timing of the flash command logic
package spwp_pkg;
	// ---------------------------------------------------------------
	// command opcodes
	// ---------------------------------------------------------------
	localparam logic [7:0] WR_ENABLE_CMD = 8'h06;
	localparam logic [7:0] WR_DISABLE_CMD = 8'h04;
	localparam logic [7:0] STATUS_READ_CMD = 8'h05;
	localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
	localparam logic [7:0] DATA_READ_CMD = 8'h03;
	localparam logic [7:0] LOCK_READ_CMD = 8'hE8;
	localparam logic [7:0] LOCK_WRITE_CMD = 8'hE5;
	localparam logic [7:0] PAGE_REWRITE_CMD = 8'h0A;
	localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
	localparam logic [7:0] PAGE_ERASE_CMD = 8'hDB;
	localparam logic [7:0] SUBSECTOR_ERASE_CMD = 8'h20;
	localparam logic [7:0] SECTOR_ERASE_CMD = 8'hD8;
	localparam logic [7:0] BULK_ERASE_CMD = 8'hC7;
	localparam logic [7:0] DEEP_PD_CMD = 8'hB9;
	localparam logic [7:0] PD_RELEASE_CMD = 8'hAB;
	// ---------------------------------------------------------------
	// byte counts within one selection (saturating at BC_DATA)
	// ---------------------------------------------------------------
	localparam logic [2:0] BC_NONE = 3'h0;
	localparam logic [2:0] BC_OP = 3'h1;
	localparam logic [2:0] BC_SR = 3'h2;
	localparam logic [2:0] BC_A3 = 3'h3;
	localparam logic [2:0] BC_HDR = 3'h4;
	localparam logic [2:0] BC_DATA = 3'h5;
	// ---------------------------------------------------------------
	// status and lock layout, reset values
	// ---------------------------------------------------------------
	localparam int SR_BP_LSB = 2;
	localparam int SR_SWD = 7;
	localparam int LOCK_WL = 0;
	localparam int LOCK_LD = 1;
	localparam logic LOCK_RESET = 1'h0;
	localparam logic [2:0] BP_RESET = 3'h0;
	localparam logic SWD_RESET = 1'h0;
	localparam logic [7:0] ERASED_BYTE = 8'hFF;
	// ---------------------------------------------------------------
	// geometry and timing
	// ---------------------------------------------------------------
	localparam int PAGE_AW = 8;
	localparam int SUBSEC_AW = 12;
	localparam int SECTOR_AW = 16;
	localparam int CLK_MHZ = 20;
	localparam int PUW_US = 50;
	localparam int PUW_CYC = PUW_US * CLK_MHZ;
	typedef enum logic [1:0] {
		CY_IDLE = 2'h0,
		CY_FILL = 2'h1,
		CY_ERASE = 2'h3,
		CY_PROG = 2'h2
	} spwp_cyc_t;
endpackage

/* File: test/spwp_ctrl_sva.sv */
// assertion checker for the flash command logic, bound to its top module
`timescale 1ns/1ps
module spwp_ctrl_sva (
	input wire logic mclk_i,
	input wire logic rst_n_i,
	input wire logic spi_clk_i,
	input wire logic cs_n_i,
	input wire logic serial_in_i,
	input wire logic wp_n_i,
	input wire logic hw_reset_n_i,
	input wire logic serial_out_o,
	input wire logic serial_out_oe_n_o,
	input wire logic write_in_progress_o,
	input wire logic standby_o,
	input wire logic deep_pd_o
);
	default clocking cb @(posedge mclk_i);
	endclocking
	default disable iff (!rst_n_i);
	// ---------------------------------------------------------------
	// sequences
	// ---------------------------------------------------------------
	// six samples leave room for the two sync flops and the output register
	sequence s_desel;
		cs_n_i [*6];
	endsequence
	sequence s_sel;
		!cs_n_i [*6];
	endsequence
	sequence s_hw_hold;
		!hw_reset_n_i [*6];
	endsequence
	// ---------------------------------------------------------------
	// properties
	// ---------------------------------------------------------------
	chk_desel_hiz: assert property (s_desel |-> serial_out_oe_n_o)
		else $error("serial output driven while deselected");
	chk_sel_active: assert property (s_sel |-> !standby_o)
		else $error("standby while selected");
	chk_busy_active: assert property (write_in_progress_o && $past(write_in_progress_o)
		|-> !standby_o)
		else $error("standby during internal cycle");
	chk_out_fall: assert property (!serial_out_oe_n_o && !$past(serial_out_oe_n_o)
		&& $changed(serial_out_o) |-> !$past(spi_clk_i))
		else $error("serial output changed outside clock low phase");
	chk_cycle_desel: assert property ($rose(write_in_progress_o)
		|-> cs_n_i && $past(cs_n_i) && $past(cs_n_i, 2))
		else $error("internal cycle started while selected");
	chk_hw_freeze: assert property (s_hw_hold
		|-> serial_out_oe_n_o && !write_in_progress_o && !deep_pd_o)
		else $error("logic active while reset pin low");
	chk_pd_idle: assert property (deep_pd_o |-> !write_in_progress_o)
		else $error("internal cycle in deep power-down");
	chk_pd_exit: assert property ($fell(deep_pd_o) |-> cs_n_i && $past(cs_n_i))
		else $error("deep power-down left while selected");
endmodule
bind spwp_ctrl spwp_ctrl_sva chk_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .spi_clk_i(spi_clk_i),
	.cs_n_i(cs_n_i), .serial_in_i(serial_in_i), .wp_n_i(wp_n_i),
	.hw_reset_n_i(hw_reset_n_i), .serial_out_o(serial_out_o),
	.serial_out_oe_n_o(serial_out_oe_n_o), .write_in_progress_o(write_in_progress_o),
	.standby_o(standby_o), .deep_pd_o(deep_pd_o));

/* File: test/spwp_spi_master.sv */
// spi bus master model: modes 0 and 3, owns clock, select and data in
`timescale 1ns/1ps
module spwp_spi_master (
	input wire logic mclk_i,
	input wire logic miso_i,
	output logic sck_o,
	output logic cs_n_o,
	output logic mosi_o
);
	logic [7:0] tx [0:7];
	logic [7:0] rx [0:7];
	logic cpol = 1'b0;
	initial begin
		sck_o = 1'b0;
		cs_n_o = 1'b1;
		mosi_o = 1'b0;
	end
	task automatic gap(input int n);
		repeat (n) @(negedge mclk_i);
	endtask
	// ---------------------------------------------------------------
	// one selection: nb whole bytes then xb stray clocks, msb first
	// ---------------------------------------------------------------
	// at most eight bytes in one selection, held in tx and rx
	task automatic frame(input int nb, input int xb);
		int i;
		sck_o = cpol;
		gap(4);
		cs_n_o = 1'b0;
		gap(4);
		for (i = 0; i < nb * 8 + xb; i++) begin
			sck_o = 1'b0;
			mosi_o = tx[i / 8][7 - i % 8];
			gap(4);
			sck_o = 1'b1;
			rx[i / 8] = {rx[i / 8][6:0], miso_i};
			gap(4);
		end
		sck_o = cpol;
		gap(4);
		cs_n_o = 1'b1;
		// released line must not keep showing the last bit
		mosi_o = ~mosi_o;
		gap(8);
	endtask
endmodule

/* File: test/test_spwp_ctrl.sv */
// self-checking bench for the flash command logic
`timescale 1ns/1ps
module test_spwp_ctrl;
	typedef struct packed {
		logic [7:0] op;
		logic [23:0] adr;
		logic [7:0] dat;
		logic [3:0] nb;
		logic [23:0] radr;
		logic [7:0] exp;
	} spwp_row_t;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic hw_rst_n = 1'b1;
	logic wp_n = 1'b1;
	logic so_last = 1'b0;
	logic sck, cs_n, mosi, so, so_oe_n, write_in_progress, stby, dpd, miso;
	logic [7:0] v;
	logic [7:0] rop;
	int error_cnt = 0;
	int n_tests = 0;
	int i;
	spwp_row_t r;
	spwp_row_t rows [0:12];
	always #25 mclk = ~mclk;
	// undriven line shows the inverse of its last driven level
	always @(posedge mclk) if (!so_oe_n) so_last <= so;
	assign miso = so_oe_n ? ~so_last : so;
	spwp_ctrl #(.MEM_AW(17), .PUW_CYCLES(10)) dut_u (.mclk_i(mclk), .rst_n_i(rst_n),
		.spi_clk_i(sck), .cs_n_i(cs_n), .serial_in_i(mosi), .wp_n_i(wp_n),
		.hw_reset_n_i(hw_rst_n), .serial_out_o(so), .serial_out_oe_n_o(so_oe_n),
		.write_in_progress_o(write_in_progress), .standby_o(stby), .deep_pd_o(dpd));
	spwp_spi_master m_u (.mclk_i(mclk), .miso_i(miso), .sck_o(sck), .cs_n_o(cs_n),
		.mosi_o(mosi));
	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task automatic chk8(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_tests++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk1(input string nm, input logic e, input logic g);
		chk8(nm, {7'h00, e}, {7'h00, g});
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	task automatic cmd(input logic [7:0] op, input logic [23:0] a, input logic [7:0] d,
		input int nb, input int xb);
		m_u.tx[0] = op;
		m_u.tx[1] = a[23:16];
		m_u.tx[2] = a[15:8];
		m_u.tx[3] = a[7:0];
		m_u.tx[4] = d;
		// stray clocks past the last byte send zeros, never unknowns
		m_u.tx[5] = 8'h00;
		m_u.frame(nb, xb);
	endtask
	task automatic wr_enable_cmd();
		cmd(spwp_pkg::WR_ENABLE_CMD, 24'h0, 8'h00, 1, 0);
	endtask
	task automatic rd(input logic [7:0] op, input logic [23:0] a, output logic [7:0] q);
		int n;
		n = (op == spwp_pkg::STATUS_READ_CMD) ? 2 : 5;
		cmd(op, a, 8'h00, n, 0);
		q = m_u.rx[n - 1];
	endtask
	// status read repeats until the busy bit drops, bounded
	task automatic poll();
		logic [7:0] s;
		int k;
		for (k = 0; k < 200; k++) begin
			rd(spwp_pkg::STATUS_READ_CMD, 24'h0, s);
			if (s[0] === 1'b0) return;
		end
		error_cnt++;
		$display("BAD poll expected 00 seen %h", s);
		conclude();
	endtask
	// ---------------------------------------------------------------
	// sequence
	// ---------------------------------------------------------------
	initial begin
		rows[0] = '{spwp_pkg::PAGE_ERASE_CMD, 24'h000100, 8'h00, 4'h4, 24'h000105, 8'hFF};
		rows[1] = '{spwp_pkg::PAGE_PROGRAM_CMD, 24'h000105, 8'hA5, 4'h5, 24'h000105, 8'hA5};
		rows[2] = '{spwp_pkg::WR_DISABLE_CMD, 24'h0, 8'h00, 4'h1, 24'h000105, 8'hA5};
		rows[3] = '{spwp_pkg::PAGE_PROGRAM_CMD, 24'h000105, 8'h5A, 4'h5, 24'h000105, 8'h00};
		rows[4] = '{spwp_pkg::PAGE_REWRITE_CMD, 24'h000105, 8'h5A, 4'h5, 24'h000105, 8'h5A};
		rows[5] = '{spwp_pkg::PAGE_REWRITE_CMD, 24'h0001FF, 8'h33, 4'h5, 24'h000105, 8'h5A};
		rows[6] = '{spwp_pkg::SUBSECTOR_ERASE_CMD, 24'h001000, 8'h00, 4'h4, 24'h001000, 8'hFF};
		rows[7] = '{spwp_pkg::PAGE_ERASE_CMD, 24'h010000, 8'h00, 4'h4, 24'h010000, 8'hFF};
		rows[8] = '{spwp_pkg::LOCK_WRITE_CMD, 24'h010000, 8'h01, 4'h5, 24'h010000, 8'h01};
		rows[9] = '{spwp_pkg::PAGE_PROGRAM_CMD, 24'h010000, 8'h00, 4'h5, 24'h010000, 8'hFF};
		rows[10] = '{spwp_pkg::LOCK_WRITE_CMD, 24'h010000, 8'h03, 4'h5, 24'h010000, 8'h03};
		rows[11] = '{spwp_pkg::LOCK_WRITE_CMD, 24'h010000, 8'h00, 4'h5, 24'h010000, 8'h03};
		rows[12] = '{spwp_pkg::SECTOR_ERASE_CMD, 24'h010000, 8'h00, 4'h4, 24'h010000, 8'hFF};
		repeat (4) @(negedge mclk);
		rst_n = 1'b1;
		repeat (20) @(negedge mclk);
		for (i = 0; i < 13; i++) begin
			r = rows[i];
			wr_enable_cmd();
			cmd(r.op, r.adr, r.dat, int'(r.nb), 0);
			poll();
			rd(spwp_pkg::STATUS_READ_CMD, 24'h0, v);
			chk8("status", 8'h00, v);
			rop = (r.op == spwp_pkg::LOCK_WRITE_CMD) ? spwp_pkg::LOCK_READ_CMD
				: spwp_pkg::DATA_READ_CMD;
			rd(rop, r.radr, v);
			chk8("readback", r.exp, v);
		end
		$display("test rows done");
		cmd(spwp_pkg::PAGE_PROGRAM_CMD, 24'h000105, 8'h00, 5, 0);
		wr_enable_cmd();
		cmd(spwp_pkg::PAGE_PROGRAM_CMD, 24'h000105, 8'h00, 5, 3);
		poll();
		rd(spwp_pkg::DATA_READ_CMD, 24'h000105, v);
		chk8("no commit", 8'h5A, v);
		rd(spwp_pkg::STATUS_READ_CMD, 24'h0, v);
		chk8("latch kept", 8'h02, v);
		$display("test refusals done");
		cmd(spwp_pkg::DEEP_PD_CMD, 24'h0, 8'h00, 1, 0);
		chk1("deep_pd", 1'b1, dpd);
		cmd(spwp_pkg::PAGE_ERASE_CMD, 24'h000100, 8'h00, 4, 0);
		cmd(spwp_pkg::PD_RELEASE_CMD, 24'h0, 8'h00, 1, 0);
		chk1("deep_pd", 1'b0, dpd);
		poll();
		rd(spwp_pkg::DATA_READ_CMD, 24'h000105, v);
		chk8("pd ignored", 8'h5A, v);
		chk1("standby", 1'b1, stby);
		$display("test deep power-down done");
		hw_rst_n = 1'b0;
		repeat (8) @(negedge mclk);
		chk1("oe_n held", 1'b1, so_oe_n);
		hw_rst_n = 1'b1;
		repeat (8) @(negedge mclk);
		rd(spwp_pkg::LOCK_READ_CMD, 24'h010000, v);
		chk8("lock cleared", 8'h00, v);
		rd(spwp_pkg::STATUS_READ_CMD, 24'h0, v);
		chk8("latch cleared", 8'h00, v);
		$display("test reset pin done");
		// mode 3 for the protection sequence
		m_u.cpol = 1'b1;
		wr_enable_cmd();
		cmd(spwp_pkg::STATUS_WRITE_CMD, 24'h800000, 8'h00, 2, 0);
		poll();
		wp_n = 1'b0;
		cmd(spwp_pkg::STATUS_WRITE_CMD, 24'h9C0000, 8'h00, 2, 0);
		poll();
		rd(spwp_pkg::STATUS_READ_CMD, 24'h0, v);
		chk8("protected status", 8'h82, v);
		wp_n = 1'b1;
		cmd(spwp_pkg::STATUS_WRITE_CMD, 24'h1C0000, 8'h00, 2, 0);
		cmd(spwp_pkg::BULK_ERASE_CMD, 24'h0, 8'h00, 1, 0);
		poll();
		rd(spwp_pkg::STATUS_READ_CMD, 24'h0, v);
		chk8("bulk refused", 8'h1C, v);
		wr_enable_cmd();
		cmd(spwp_pkg::STATUS_WRITE_CMD, 24'h0, 8'h00, 2, 0);
		m_u.cpol = 1'b0;
		$display("test protection done");
		rst_n = 1'b0;
		@(negedge mclk);
		chk1("oe_n reset", 1'b1, so_oe_n);
		chk1("wip reset", 1'b0, write_in_progress);
		rst_n = 1'b1;
		repeat (20) @(negedge mclk);
		rd(spwp_pkg::STATUS_READ_CMD, 24'h0, v);
		chk8("power-up status", 8'h00, v);
		$display("test power-up done");
		conclude();
	end
endmodule
